/* File: src/dsp_pkg.sv */
package dsp_pkg;
    // Register map, word index on the plain port
    localparam int ADDR_W = 3;
    localparam logic [2:0] OFS_CTRL_A = 3'h0;
    localparam logic [2:0] OFS_BUF_A  = 3'h1;
    localparam logic [2:0] OFS_CTRL_B = 3'h2;
    localparam logic [2:0] OFS_BUF_B  = 3'h3;
    localparam logic [2:0] OFS_RATE   = 3'h4;

    // Control register fields
    localparam int CTL_MODE_HI = 7;
    localparam int CTL_MODE_LO = 6;
    localparam int CTL_MP      = 5;
    localparam int CTL_RXEN    = 4;
    localparam int CTL_TX9     = 3;
    localparam int CTL_RX9     = 2;
    localparam int CTL_TXF     = 1;
    localparam int CTL_RXF     = 0;

    // Rate register fields
    localparam int RATE_DOUBLE = 0;
    localparam int RATE_TX_T2A = 1;
    localparam int RATE_RX_T2A = 2;
    localparam int RATE_TX_T2B = 3;
    localparam int RATE_RX_T2B = 4;

    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [4:0] RATE_RST = 5'h00;

    // Timing counts in oscillator cycles or 16x ticks
    localparam logic [3:0] PHASE_LAST   = 4'hb;
    localparam logic [3:0] PHASE_RISE   = 4'h6;
    localparam logic [3:0] PHASE_SAMPLE = 4'h8;
    localparam logic [1:0] PRE_SLOW     = 2'h3;
    localparam logic [3:0] SUB_LAST     = 4'hf;
    localparam logic [3:0] VOTE_A       = 4'h7;
    localparam logic [3:0] VOTE_B       = 4'h8;
    localparam logic [3:0] VOTE_DECIDE  = 4'h9;
    localparam logic [3:0] MODE0_LAST   = 4'h7;
    localparam logic [3:0] LAST_BIT_10  = 4'h9;
    localparam logic [3:0] LAST_BIT_11  = 4'ha;

    typedef enum logic [1:0] {
        MODE_SHIFT   = 2'b00,
        MODE_ASYNC10 = 2'b01,
        MODE_FIX11   = 2'b10,
        MODE_VAR11   = 2'b11
    } dsp_mode_t;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } dsp_bus_t;

    typedef struct packed {
        logic txPin;
        logic rxOut;
        logic rxDriveN;
    } dsp_pins_t;

    typedef struct packed {
        logic [7:0]  ctrl;
        logic [7:0]  rxHold;
        logic [10:0] txShift;
        logic [3:0]  txCnt;
        logic [3:0]  txSub;
        logic        txBusy;
        logic [8:0]  rxShift;
        logic [3:0]  rxCnt;
        logic [3:0]  rxSub;
        logic        rxBusy;
        logic [1:0]  votes;
        logic [1:0]  rxSync;
        logic        rxPrev;
        dsp_pins_t   pins;
    } dsp_port_t;

    typedef struct packed {
        dsp_port_t [1:0] port;
        logic [4:0]      rate;
        logic [3:0]      phase;
        logic [1:0]      pre;
        logic            t1Half;
        logic [7:0]      rdData;
    } dsp_state_t;
endpackage

/* File: src/dsp_serial_top.sv */
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module dsp_serial_top (
    // Clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 rst,
    // Register port
    input  wire dsp_pkg::dsp_bus_t    busReq,
    output logic [7:0]                rdData,
    // Rate sources, same clock
    input  wire logic                 timer1Ovf,
    input  wire logic                 timer2Ovf,
    // Line pins, one per port
    input  wire logic [1:0]           rxdIn,
    output dsp_pkg::dsp_pins_t [1:0]  pinOut
);
    import dsp_pkg::*;

    dsp_state_t s;
    dsp_state_t n;

    function automatic logic rateTick(dsp_mode_t m, logic useT2, logic dbl,
                                      logic t1, logic t2, logic half,
                                      logic [1:0] pre);
        if (m == MODE_FIX11) begin
            return dbl ? pre[0] : (pre == PRE_SLOW);
        end
        if (useT2) begin
            return t2;
        end
        return t1 & (dbl | half);
    endfunction

    always_comb begin
        dsp_port_t p;
        dsp_mode_t m;
        logic      txTick;
        logic      rxTick;
        logic      bitVal;
        logic      done;
        logic      accept;
        logic      ctlWr;
        logic      bufWr;
        logic [7:0] rxData;
        logic      rxNinth;
        logic [3:0] lastBit;
        p = '0;
        m = MODE_SHIFT;
        txTick = 1'b0;
        rxTick = 1'b0;
        bitVal = 1'b0;
        done = 1'b0;
        accept = 1'b0;
        ctlWr = 1'b0;
        bufWr = 1'b0;
        rxData = 8'h00;
        rxNinth = 1'b0;
        lastBit = 4'h0;
        n = s;
        n.phase = (s.phase == PHASE_LAST) ? 4'h0 : s.phase + 4'h1;
        n.pre = s.pre + 2'h1;
        if (timer1Ovf) begin
            n.t1Half = ~s.t1Half;
        end
        if (busReq.wr && busReq.addr == OFS_RATE) begin
            n.rate = busReq.wdata[4:0];
        end
        for (int i = 0; i < 2; i++) begin
            p = s.port[i];
            ctlWr = busReq.wr && busReq.addr == (i == 0 ? OFS_CTRL_A : OFS_CTRL_B);
            bufWr = busReq.wr && busReq.addr == (i == 0 ? OFS_BUF_A : OFS_BUF_B);
            m = dsp_mode_t'(s.port[i].ctrl[CTL_MODE_HI:CTL_MODE_LO]);
            txTick = rateTick(m, s.rate[i == 0 ? RATE_TX_T2A : RATE_TX_T2B],
                              s.rate[RATE_DOUBLE], timer1Ovf, timer2Ovf,
                              s.t1Half, s.pre);
            rxTick = rateTick(m, s.rate[i == 0 ? RATE_RX_T2A : RATE_RX_T2B],
                              s.rate[RATE_DOUBLE], timer1Ovf, timer2Ovf,
                              s.t1Half, s.pre);
            lastBit = (m == MODE_ASYNC10) ? LAST_BIT_10 : LAST_BIT_11;
            p.rxSync = {s.port[i].rxSync[0], rxdIn[i]};
            p.rxPrev = s.port[i].rxSync[1];
            if (ctlWr) begin
                p.ctrl = busReq.wdata;
            end

            // Transmitter, independent of receiver
            // start on buffer write
            if (bufWr) begin
                p.txBusy = 1'b1;
                p.txSub = 4'h0;
                p.txCnt = 4'h0;
                if (m == MODE_SHIFT) begin
                    p.txShift = {3'h7, busReq.wdata};
                end else begin
                    p.txShift = {1'b1,
                                 (m == MODE_ASYNC10) ? 1'b1 : s.port[i].ctrl[CTL_TX9],
                                 busReq.wdata, 1'b0};
                end
            end else if (s.port[i].txBusy) begin
                if (m == MODE_SHIFT) begin
                    // Low clock phase shown, so a rise will follow
                    if (s.phase < PHASE_RISE) begin
                        p.txSub = 4'h1;
                    end
                    // one bit per twelve cycles, never before a rise
                    if (s.phase == PHASE_LAST && s.port[i].txSub[0]) begin
                        p.txSub = 4'h0;
                        p.txShift = {1'b1, s.port[i].txShift[10:1]};
                        p.txCnt = s.port[i].txCnt + 4'h1;
                        if (s.port[i].txCnt == MODE0_LAST) begin
                            p.txBusy = 1'b0;
                            p.ctrl[CTL_TXF] = 1'b1;
                        end
                    end
                end else if (txTick) begin
                    p.txSub = s.port[i].txSub + 4'h1;
                    if (s.port[i].txSub == SUB_LAST) begin
                        p.txShift = {1'b1, s.port[i].txShift[10:1]};
                        p.txCnt = s.port[i].txCnt + 4'h1;
                        if (s.port[i].txCnt + 4'h1 == lastBit) begin
                            p.ctrl[CTL_TXF] = 1'b1;
                        end
                        if (s.port[i].txCnt == lastBit) begin
                            p.txBusy = 1'b0;
                        end
                    end
                end
            end

            // Receiver
            if (m == MODE_SHIFT) begin
                if (!s.port[i].rxBusy && s.port[i].ctrl[CTL_RXEN]
                    && !s.port[i].ctrl[CTL_RXF]) begin
                    p.rxBusy = 1'b1;
                    p.rxCnt = 4'h0;
                end else if (s.port[i].rxBusy && s.phase == PHASE_SAMPLE) begin
                    p.rxShift = {s.port[i].rxSync[1], s.port[i].rxShift[8:1]};
                    p.rxCnt = s.port[i].rxCnt + 4'h1;
                    if (s.port[i].rxCnt == MODE0_LAST) begin
                        p.rxBusy = 1'b0;
                        done = 1'b1;
                        rxData = p.rxShift[8:1];
                    end
                end
            end else if (!s.port[i].rxBusy) begin
                if (s.port[i].ctrl[CTL_RXEN] && s.port[i].rxPrev
                    && !s.port[i].rxSync[1]) begin
                    p.rxBusy = 1'b1;
                    p.rxSub = 4'h0;
                    p.rxCnt = 4'h0;
                end
            end else if (rxTick) begin
                p.rxSub = s.port[i].rxSub + 4'h1;
                if (s.port[i].rxSub == VOTE_A) begin
                    p.votes[0] = s.port[i].rxSync[1];
                end
                if (s.port[i].rxSub == VOTE_B) begin
                    p.votes[1] = s.port[i].rxSync[1];
                end
                if (s.port[i].rxSub == VOTE_DECIDE) begin
                    bitVal = (s.port[i].votes[0] & s.port[i].votes[1])
                           | (s.port[i].votes[0] & s.port[i].rxSync[1])
                           | (s.port[i].votes[1] & s.port[i].rxSync[1]);
                    if (s.port[i].rxCnt == 4'h0 && bitVal) begin
                        p.rxBusy = 1'b0;
                    end else if (s.port[i].rxCnt == lastBit) begin
                        p.rxBusy = 1'b0;
                        done = 1'b1;
                        if (m == MODE_ASYNC10) begin
                            rxData = s.port[i].rxShift[8:1];
                            rxNinth = bitVal;
                        end else begin
                            rxData = s.port[i].rxShift[7:0];
                            rxNinth = s.port[i].rxShift[8];
                        end
                    end else begin
                        if (s.port[i].rxCnt != 4'h0) begin
                            p.rxShift = {bitVal, s.port[i].rxShift[8:1]};
                        end
                        p.rxCnt = s.port[i].rxCnt + 4'h1;
                    end
                end
            end

            accept = done && !s.port[i].ctrl[CTL_RXF]
                     && (m == MODE_SHIFT || !s.port[i].ctrl[CTL_MP] || rxNinth);
            if (accept) begin
                p.rxHold = rxData;
                p.ctrl[CTL_RXF] = 1'b1;
                if (m != MODE_SHIFT) begin
                    p.ctrl[CTL_RX9] = rxNinth;
                end
            end

            // Pin drive, shift clock low in first half
            if (m == MODE_SHIFT) begin
                p.pins.txPin = ~((p.txBusy | p.rxBusy) && n.phase < PHASE_RISE);
                p.pins.rxOut = p.txShift[0];
                p.pins.rxDriveN = ~p.txBusy;
            end else begin
                p.pins.txPin = p.txBusy ? p.txShift[0] : 1'b1;
                p.pins.rxOut = 1'b1;
                p.pins.rxDriveN = 1'b1;
            end
            n.port[i] = p;
        end

        n.rdData = 8'h00;
        if (busReq.rd) begin
            unique case (busReq.addr)
                OFS_CTRL_A: n.rdData = s.port[0].ctrl;
                OFS_BUF_A:  n.rdData = s.port[0].rxHold;
                OFS_CTRL_B: n.rdData = s.port[1].ctrl;
                OFS_BUF_B:  n.rdData = s.port[1].rxHold;
                OFS_RATE:   n.rdData = {3'h0, s.rate};
                default:    n.rdData = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            s <= '0;
            s.port[0].ctrl <= CTRL_RST;
            s.port[1].ctrl <= CTRL_RST;
            s.port[0].rxSync <= 2'h3;
            s.port[1].rxSync <= 2'h3;
            s.port[0].rxPrev <= 1'b1;
            s.port[1].rxPrev <= 1'b1;
            s.port[0].pins <= 3'h7;
            s.port[1].pins <= 3'h7;
            s.rate <= RATE_RST;
        end else begin
            s <= n;
        end
    end

    assign rdData = s.rdData;
    generate
        for (genvar g = 0; g < 2; g++) begin : gPin
            assign pinOut[g] = s.port[g].pins;
        end
    endgenerate

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    AST_TX_START: assert property (
        busReq.wr && busReq.addr == OFS_BUF_A |=> s.port[0].txBusy && s.port[0].txCnt == 4'h0)
        else $error("buffer write did not start transmit");

    AST_TX_ONLY_WRITE: assert property (
        $rose(s.port[0].txBusy) |-> $past(busReq.wr && busReq.addr == OFS_BUF_A))
        else $error("transmit started without buffer write");

    AST_BUF_SEPARATE: assert property (
        busReq.rd && busReq.addr == OFS_BUF_A |=> rdData == $past(s.port[0].rxHold))
        else $error("buffer read did not return receive register");

    AST_RX_ENABLE: assert property (
        $rose(s.port[0].rxBusy) |-> $past(s.port[0].ctrl[CTL_RXEN]))
        else $error("reception started while disabled");

    AST_MODE0_RX: assert property (
        $rose(s.port[0].rxBusy) && s.port[0].ctrl[7:6] == 2'b00
        |-> $past(!s.port[0].ctrl[CTL_RXF]))
        else $error("shift receive started with flag set");

    AST_SHIFT_CLK: assert property (
        s.port[0].ctrl[7:6] == 2'b00 && s.port[0].txBusy && $rose(s.port[0].pins.txPin)
        |-> ##6 (!s.port[0].pins.txPin || !s.port[0].txBusy))
        else $error("shift clock high phase not six cycles");

    AST_TXF_HOLD: assert property (
        s.port[0].ctrl[CTL_TXF] && !(busReq.wr && busReq.addr == OFS_CTRL_A)
        |=> s.port[0].ctrl[CTL_TXF])
        else $error("transmit flag cleared by hardware");

    AST_MP_FILTER: assert property (
        $rose(s.port[0].ctrl[CTL_RXF]) && s.port[0].ctrl[CTL_MODE_HI]
        && s.port[0].ctrl[CTL_MP] && !$past(busReq.wr && busReq.addr == OFS_CTRL_A)
        |-> s.port[0].ctrl[CTL_RX9])
        else $error("filtered frame raised receive flag");

    AST_OVERRUN_KEEP: assert property (
        s.port[0].ctrl[CTL_RXF] |=> $stable(s.port[0].rxHold))
        else $error("unread byte overwritten");
endmodule

/* File: testbench/dsp_line_model.sv */
`timescale 1ns/1ps
module dsp_line_model (
    // Line from the port under test
    input  wire logic txd,
    input  wire logic sdat,
    // Line into the port, idle high like a pulled-up wire
    output logic      rxd
);
    initial rxd = 1'b1;

    // start low, LSB first, stop high
    task automatic send(input logic [9:0] bits, input int n, input int per);
        rxd = 1'b0;
        #(per * 10);
        for (int i = 0; i < n; i++) begin
            rxd = bits[i];
            #(per * 10);
        end
        // Hold the stop bit for a full bit time
        rxd = 1'b1;
        #(per * 10);
    endtask

    // sample each bit near its middle
    task automatic recv(output logic [9:0] bits, input int n, input int per);
        bits = '0;
        @(negedge txd);
        #(per * 5);
        for (int i = 0; i < n; i++) begin
            #(per * 10);
            bits[i] = txd;
        end
    endtask

    // Shift register partner, data taken on each clock rise
    task automatic shift_recv(output logic [7:0] d, output int per);
        time last;
        last = 0;
        per = 0;
        for (int i = 0; i < 8; i++) begin
            @(posedge txd);
            d[i] = sdat;
            per = int'($time - last);
            last = $time;
        end
    endtask
endmodule

/* File: testbench/dual_async_serial_port_bench.sv */
`timescale 1ns/1ps
module dual_async_serial_port_bench;
    import dsp_pkg::*;

    logic                core_clk;
    logic                rst;
    dsp_bus_t            busReq;
    logic [7:0]          rdData;
    logic                timer1Ovf;
    logic                timer2Ovf;
    logic [1:0]          rxdIn;
    dsp_pins_t [1:0]     pinOut;
    logic                lineA;
    logic                lineB;
    int                  err_total;
    int                  check_count;

    dsp_serial_top uut (
        .core_clk  (core_clk),
        .rst       (rst),
        .busReq    (busReq),
        .rdData    (rdData),
        .timer1Ovf (timer1Ovf),
        .timer2Ovf (timer2Ovf),
        .rxdIn     (rxdIn),
        .pinOut    (pinOut)
    );

    // Shared rx pin: device drives it only in shift transmit
    assign rxdIn[0] = pinOut[0].rxDriveN ? lineA : pinOut[0].rxOut;
    assign rxdIn[1] = pinOut[1].rxDriveN ? lineB : pinOut[1].rxOut;

    dsp_line_model mA (.txd(pinOut[0].txPin), .sdat(rxdIn[0]), .rxd(lineA));
    dsp_line_model mB (.txd(pinOut[1].txPin), .sdat(rxdIn[1]), .rxd(lineB));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // Overflow pulse every second clock: 32 clocks per bit
    always @(posedge core_clk) begin
        timer1Ovf <= ~timer1Ovf;
        timer2Ovf <= ~timer2Ovf;
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk);
        busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        busReq.wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
        @(posedge core_clk);
        busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        busReq.rd <= 1'b0;
        #1 d = rdData;
    endtask

    task automatic rd_chk(input string what, input logic [2:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd_reg(a, d);
        check(what, {8'h00, d}, {8'h00, exp});
    endtask

    task automatic t_reset();
        rd_chk("ctrl a reset", OFS_CTRL_A, CTRL_RST);
        rd_chk("ctrl b reset", OFS_CTRL_B, CTRL_RST);
        rd_chk("rate reset", OFS_RATE, {3'h0, RATE_RST});
        wr_reg(3'h5, 8'hff);
        rd_chk("unmapped", 3'h5, 8'h00);
        check("tx idle", {14'h0, pinOut[0].txPin, pinOut[1].txPin}, 16'h3);
    endtask

    task automatic t_fix_tx();
        logic [9:0] bits;
        wr_reg(OFS_RATE, 8'h01);
        wr_reg(OFS_CTRL_A, 8'h88);
        fork
            mA.recv(bits, 10, 32);
            wr_reg(OFS_BUF_A, 8'ha5);
        join
        check("fixed frame", {6'h0, bits}, {6'h0, 2'b11, 8'ha5});
        rd_chk("ctrl a tx done", OFS_CTRL_A, 8'h8a);
        rd_chk("buf a read side", OFS_BUF_A, 8'h00);
    endtask

    task automatic t_var_rx_b();
        wr_reg(OFS_RATE, 8'h11);
        wr_reg(OFS_CTRL_B, 8'hf0);
        mB.send({2'b10, 8'h5a}, 10, 32);
        rd_chk("filtered frame", OFS_CTRL_B, 8'hf0);
        mB.send({2'b11, 8'h3c}, 10, 32);
        rd_chk("ctrl b accepted", OFS_CTRL_B, 8'hf5);
        rd_chk("buf b data", OFS_BUF_B, 8'h3c);
        mB.send({2'b11, 8'hc3}, 10, 32);
        rd_chk("overrun keeps byte", OFS_BUF_B, 8'h3c);
        rd_chk("port a untouched", OFS_CTRL_A, 8'h8a);
    endtask

    task automatic t_async10_duplex();
        logic [9:0] bits;
        wr_reg(OFS_RATE, 8'h01);
        wr_reg(OFS_CTRL_A, 8'h50);
        fork
            mA.send({2'b01, 8'h3c}, 9, 32);
            mA.recv(bits, 9, 32);
            wr_reg(OFS_BUF_A, 8'hc6);
        join
        check("10 bit frame", {6'h0, bits}, {6'h0, 2'b01, 8'hc6});
        rd_chk("ctrl a duplex", OFS_CTRL_A, 8'h57);
        rd_chk("buf a rx", OFS_BUF_A, 8'h3c);
        wr_reg(OFS_CTRL_A, 8'h40);
        mA.send({2'b01, 8'h99}, 9, 32);
        rd_chk("rx disabled", OFS_CTRL_A, 8'h40);
    endtask

    task automatic t_shift();
        logic [7:0] d;
        int         per;
        wr_reg(OFS_CTRL_A, 8'h00);
        fork
            mA.shift_recv(d, per);
            wr_reg(OFS_BUF_A, 8'h96);
        join
        check("shift data", {8'h00, d}, 16'h0096);
        check("shift period ns", 16'(per), 16'd120);
        repeat (24) @(posedge core_clk);
        rd_chk("shift tx done", OFS_CTRL_A, 8'h02);
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        #500000;
        err_total++;
        finish_test();
    end

    initial begin
        rst = 1'b1;
        busReq = '0;
        timer1Ovf = 1'b0;
        timer2Ovf = 1'b0;
        err_total = 0;
        check_count = 0;
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        t_reset();
        t_fix_tx();
        t_var_rx_b();
        t_async10_duplex();
        t_shift();
        finish_test();
    end
endmodule
